// ---- inc/salr_consts.svh ----
// Overview of operation
// RQ1 - Light the keypad display whenever control power is present.
// RQ2 - Permit motor run only with control power, main power and no alarm.
// RQ3 - On alarm detection switch the display to the alarm code.
// RQ4 - Blink the orange indicator every half second while an alarm stands.
// RQ5 - Host pulses fault clear on then off; the release is a reset request.
// RQ6 - Keypad test menu item 005 executes an alarm reset.
// RQ7 - Up and down held together one second on alarm screen resets.
// RQ8 - Software alarm reset command clears alarms.
// RQ9 - After a clear show the display item chosen by post-clear select.
// RQ10 - Reset requests clear the resettable alarm class.
// RQ11 - Serious alarms ignore reset requests; only power cycling clears them.
// RQ12 - A keypad reset clears only the alarm currently shown.
// RQ13 - Raise overcurrent when output current exceeds the rated value.
// RQ14 - Report hardware trip and firmware-inferred overcurrent as two codes.
// RQ15 - Raise overspeed when speed exceeds 1.1 times maximum speed.
// RQ16 - Alarms stay latched until a reset their class allows or power cycle.
`ifndef SALR_CONSTS_SVH
`define SALR_CONSTS_SVH
// Register byte offsets
`define SALR_OFF_CTRL 8'h00
`define SALR_OFF_ALARM 8'h04
`define SALR_OFF_INFO 8'h08
`define SALR_OFF_ISTAT 8'h0C
`define SALR_OFF_IMASK 8'h10
`define SALR_OFF_RATED 8'h14
`define SALR_OFF_MAXSPD 8'h18
// Field positions
`define SALR_CTRL_RST_BIT 0
`define SALR_CTRL_SEL_LSB 4
`define SALR_IRQ_RAISE_BIT 0
`define SALR_IRQ_CLEAR_BIT 1
// Alarm vector positions used by the detectors
`define SALR_AL_OC_HW 0
`define SALR_AL_OC_FW 1
`define SALR_AL_OSPD 2
// Alarms that a reset request may clear
`define SALR_RESETTABLE 29'h1077D81F
// Reset values
`define SALR_RST_RATED 16'hFFFF
`define SALR_RST_MAXSPD 16'hFFFF
`define SALR_RST_SEL 4'h0
// Timing
`define SALR_CLK_KHZ 50000
`define SALR_BLINK_MS 500
`define SALR_HOLD_MS 1000
`define SALR_BLINK_CYC (`SALR_BLINK_MS * `SALR_CLK_KHZ)
`define SALR_HOLD_CYC (`SALR_HOLD_MS * `SALR_CLK_KHZ)
`endif

// ---- inc/salr_pkg.sv ----
package salr_pkg;
    localparam int SALR_N_ALARMS = 29;
    // Synchronised pin group
    typedef struct packed {
        logic ctrl_pwr;   // Control power present
        logic main_pwr;   // Main circuit power present
        logic fault_clr;  // Host fault clear sequence input
        logic key_up;     // Up key pressed
        logic key_down;   // Down key pressed
        logic oc_hw_trip; // Transistor overcurrent trip
    } salr_pins_t;
    // Keypad display and indicator group
    typedef struct packed {
        logic lit;
        logic show_alarm;
        logic [4:0] code;
        logic [3:0] item;
        logic led_orange;
    } salr_disp_t;
    typedef enum logic [2:0] {
        ST_STATUS = 3'b001,
        ST_ALARM = 3'b010,
        ST_POST = 3'b100
    } salr_state_t;
endpackage

// ---- logic/salr_top.sv ----
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`include "salr_consts.svh"
module salr_top import salr_pkg::*; #(
    parameter int BLINK_CYC = `SALR_BLINK_CYC,
    parameter int HOLD_CYC = `SALR_HOLD_CYC
) (
    input wire logic core_clk, // System clock
    input wire logic reset_n, // Async reset, also power cycle
    input wire salr_pins_t pins, // Asynchronous pins
    input wire logic [SALR_N_ALARMS-1:0] alarm_det, // Detector levels
    input wire logic keypad_test_menu_item, // Keypad reset execute pulse
    input wire logic [15:0] current_meas, // Output current sample
    input wire logic [15:0] speed_meas, // Motor speed sample
    input wire logic [7:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [7:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output salr_disp_t disp, // Keypad display and indicator
    output logic charge_led, // Charge indicator
    output logic run_permit, // Motor operation allowed
    output logic irq // Interrupt level
);
    localparam int BW = $clog2(BLINK_CYC + 1);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam int N = SALR_N_ALARMS;
    localparam logic [N-1:0] RESMASK = `SALR_RESETTABLE;

    // True for a mapped register offset
    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `SALR_OFF_CTRL) || (a == `SALR_OFF_ALARM) ||
            (a == `SALR_OFF_INFO) || (a == `SALR_OFF_ISTAT) ||
            (a == `SALR_OFF_IMASK) || (a == `SALR_OFF_RATED) ||
            (a == `SALR_OFF_MAXSPD);
    endfunction

    // Byte-lane merge of a write
    function automatic logic [31:0] merge(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] st);
        logic [31:0] m;
        m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
        merge = (old & ~m) | (nw & m);
    endfunction

    // Code of the lowest pending alarm, zero when none
    function automatic logic [4:0] cur_code(input logic [N-1:0] v);
        cur_code = 5'h00;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                cur_code = 5'(i + 1);
            end
        end
    endfunction

    salr_pins_t s1_r, s2_r;
    logic fclr_d_r;
    logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
    logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic [3:0] sel_r, sel_nxt;
    logic [1:0] imask_r, imask_nxt, istat_r, istat_nxt;
    logic [15:0] rated_r, rated_nxt, maxspd_r, maxspd_nxt;
    logic sw_req_r, sw_req_nxt;
    logic [N-1:0] alarm_r, alarm_nxt;
    salr_state_t state_r, state_nxt;
    salr_disp_t disp_r, disp_nxt;
    logic [BW-1:0] blink_r, blink_nxt;
    logic [HW-1:0] hold_r, hold_nxt;
    logic led_r, led_nxt;
    logic wr_go, rd_go, seq_req, key_hold_req, key_req, glob_clr, any_r;
    logic [N-1:0] det, key_sel;
    logic [19:0] spd_x10, max_x11;
    logic [31:0] wval;

    // Two-stage synchronisers for every pin
    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            fclr_d_r <= 1'b0;
        end
        else
        begin
            s1_r <= pins;
            s2_r <= s1_r;
            fclr_d_r <= s2_r.fault_clr;
        end
    end

    // Bus handshakes: write address and data are taken together
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
    assign rd_go = s_axi_arvalid && !rvalid_r;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign any_r = |alarm_r;

    // Detectors: two overcurrent codes and overspeed
    assign spd_x10 = {4'h0, speed_meas} * 20'd10;
    assign max_x11 = {4'h0, maxspd_r} * 20'd11;
    always_comb
    begin
        det = alarm_det;
        det[`SALR_AL_OC_HW] = s2_r.oc_hw_trip; // see RQ13 see RQ14
        det[`SALR_AL_OC_FW] = current_meas > rated_r; // see RQ13 see RQ14
        det[`SALR_AL_OSPD] = spd_x10 > max_x11; // see RQ15
    end

    // Reset request sources
    assign seq_req = fclr_d_r && !s2_r.fault_clr; // see RQ5
    assign key_hold_req = (state_r == ST_ALARM) && s2_r.key_up && s2_r.key_down &&
        (hold_r == HW'(HOLD_CYC - 1)); // see RQ7
    assign key_req = keypad_test_menu_item || key_hold_req; // see RQ6
    assign glob_clr = seq_req || sw_req_r; // see RQ8
    assign key_sel = N'(1) << (cur_code(alarm_r) - 5'h01); // see RQ12

    // Register file and bus responses
    always_comb
    begin
        bvalid_nxt = bvalid_r && !s_axi_bready;
        bresp_nxt = bresp_r;
        rvalid_nxt = rvalid_r && !s_axi_rready;
        rresp_nxt = rresp_r;
        rdata_nxt = rdata_r;
        sel_nxt = sel_r;
        imask_nxt = imask_r;
        rated_nxt = rated_r;
        maxspd_nxt = maxspd_r;
        sw_req_nxt = 1'b0;
        wval = 32'h0000_0000;
        istat_nxt = istat_r;
        if (wr_go)
        begin
            bvalid_nxt = 1'b1;
            bresp_nxt = reg_hit(s_axi_awaddr) ? 2'b00 : 2'b10;
            case (s_axi_awaddr)
                `SALR_OFF_CTRL:
                begin
                    wval = merge({24'h0, sel_r, 4'h0}, s_axi_wdata, s_axi_wstrb);
                    sel_nxt = wval[`SALR_CTRL_SEL_LSB +: 4];
                    sw_req_nxt = wval[`SALR_CTRL_RST_BIT];
                end
                `SALR_OFF_ISTAT:
                begin
                    wval = merge(32'h0, s_axi_wdata, s_axi_wstrb);
                    istat_nxt = istat_r & ~wval[1:0];
                end
                `SALR_OFF_IMASK:
                begin
                    wval = merge({30'h0, imask_r}, s_axi_wdata, s_axi_wstrb);
                    imask_nxt = wval[1:0];
                end
                `SALR_OFF_RATED:
                begin
                    wval = merge({16'h0, rated_r}, s_axi_wdata, s_axi_wstrb);
                    rated_nxt = wval[15:0];
                end
                `SALR_OFF_MAXSPD:
                begin
                    wval = merge({16'h0, maxspd_r}, s_axi_wdata, s_axi_wstrb);
                    maxspd_nxt = wval[15:0];
                end
                default: wval = 32'h0000_0000;
            endcase
        end
        // Events set the sticky bits after any clear, so set wins
        if (|(det & ~alarm_r)) istat_nxt[`SALR_IRQ_RAISE_BIT] = 1'b1;
        if (any_r && (alarm_nxt == '0)) istat_nxt[`SALR_IRQ_CLEAR_BIT] = 1'b1;
        if (rd_go)
        begin
            rvalid_nxt = 1'b1;
            rresp_nxt = reg_hit(s_axi_araddr) ? 2'b00 : 2'b10;
            case (s_axi_araddr)
                `SALR_OFF_CTRL: rdata_nxt = {24'h0, sel_r, 4'h0};
                `SALR_OFF_ALARM: rdata_nxt = {3'h0, alarm_r};
                `SALR_OFF_INFO: rdata_nxt = {20'h0, disp_r.led_orange, run_permit,
                    charge_led, disp_r.lit, 3'h0, disp_r.code};
                `SALR_OFF_ISTAT: rdata_nxt = {30'h0, istat_r};
                `SALR_OFF_IMASK: rdata_nxt = {30'h0, imask_r};
                `SALR_OFF_RATED: rdata_nxt = {16'h0, rated_r};
                `SALR_OFF_MAXSPD: rdata_nxt = {16'h0, maxspd_r};
                default: rdata_nxt = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            bvalid_r <= 1'b0;
            bresp_r <= 2'b00;
            rvalid_r <= 1'b0;
            rresp_r <= 2'b00;
            rdata_r <= 32'h0000_0000;
            sel_r <= `SALR_RST_SEL;
            imask_r <= 2'h0;
            istat_r <= 2'h0;
            rated_r <= `SALR_RST_RATED;
            maxspd_r <= `SALR_RST_MAXSPD;
            sw_req_r <= 1'b0;
        end
        else
        begin
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            rvalid_r <= rvalid_nxt;
            rresp_r <= rresp_nxt;
            rdata_r <= rdata_nxt;
            sel_r <= sel_nxt;
            imask_r <= imask_nxt;
            istat_r <= istat_nxt;
            rated_r <= rated_nxt;
            maxspd_r <= maxspd_nxt;
            sw_req_r <= sw_req_nxt;
        end
    end

    // Alarm latch, display state and indicator outputs
    always_comb
    begin
        alarm_nxt = alarm_r;
        if (glob_clr) alarm_nxt = alarm_nxt & ~RESMASK; // see RQ10 see RQ11
        if (key_req) alarm_nxt = alarm_nxt & ~(key_sel & RESMASK); // see RQ12 see RQ11
        alarm_nxt = alarm_nxt | det; // see RQ16
        case (state_r)
            ST_STATUS: state_nxt = (|alarm_nxt) ? ST_ALARM : ST_STATUS;
            ST_ALARM: state_nxt = (|alarm_nxt) ? ST_ALARM : ST_POST; // see RQ9
            ST_POST: state_nxt = (|alarm_nxt) ? ST_ALARM : ST_POST;
            default: state_nxt = ST_STATUS;
        endcase
        disp_nxt.lit = s2_r.ctrl_pwr; // see RQ1
        disp_nxt.show_alarm = state_nxt == ST_ALARM; // see RQ3
        disp_nxt.code = cur_code(alarm_nxt); // see RQ3
        disp_nxt.item = (state_nxt == ST_POST) ? sel_r : 4'h0; // see RQ9
        disp_nxt.led_orange = led_r;
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            alarm_r <= '0;
            state_r <= ST_STATUS;
            disp_r <= '0;
            charge_led <= 1'b0;
        end
        else
        begin
            alarm_r <= alarm_nxt;
            state_r <= state_nxt;
            disp_r <= disp_nxt;
            charge_led <= s2_r.main_pwr;
        end
    end

    assign disp = disp_r;
    assign run_permit = disp_r.lit && charge_led && !any_r; // see RQ2
    assign irq = |(istat_r & imask_r);

    // Half-second blink and one-second key hold timers
    always_comb
    begin
        blink_nxt = '0;
        led_nxt = 1'b0;
        hold_nxt = '0;
        if (any_r)
        begin
            blink_nxt = (blink_r == BW'(BLINK_CYC - 1)) ? '0 : blink_r + BW'(1);
            led_nxt = (blink_r == BW'(BLINK_CYC - 1)) ? !led_r : led_r; // see RQ4
        end
        if ((state_r == ST_ALARM) && s2_r.key_up && s2_r.key_down)
        begin
            hold_nxt = (hold_r == HW'(HOLD_CYC)) ? hold_r : hold_r + HW'(1); // see RQ7
        end
    end

    always_ff @(posedge core_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            blink_r <= '0;
            led_r <= 1'b0;
            hold_r <= '0;
        end
        else
        begin
            blink_r <= blink_nxt;
            led_r <= led_nxt;
            hold_r <= hold_nxt;
        end
    end

    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    property p_lit;
        (reset_n && pins.ctrl_pwr) [*3] |=> disp.lit;
    endproperty
    a_lit: assert property (p_lit) else $error("display not lit"); // see RQ1
    property p_run;
        run_permit |-> $past(s2_r.ctrl_pwr) && $past(s2_r.main_pwr) && (alarm_r == '0);
    endproperty
    a_run: assert property (p_run) else $error("run permitted wrongly"); // see RQ2
    property p_show;
        $rose(any_r) |-> disp.show_alarm && (disp.code != 5'h00);
    endproperty
    a_show: assert property (p_show) else $error("alarm code not shown"); // see RQ3
    property p_blink;
        $changed(led_r) |-> ($past(any_r) && ($past(blink_r) == BW'(BLINK_CYC - 1))) ||
            (!$past(any_r) && !led_r);
    endproperty
    a_blink: assert property (p_blink) else $error("blink period wrong"); // see RQ4
    property p_hold;
        key_hold_req |-> $past(s2_r.key_up, 1) && (hold_r == HW'(HOLD_CYC - 1));
    endproperty
    a_hold: assert property (p_hold) else $error("hold reset too early"); // see RQ7
    property p_serious;
        (($past(alarm_r) & ~alarm_r) & ~RESMASK) == '0;
    endproperty
    a_serious: assert property (p_serious) else $error("serious alarm cleared"); // see RQ11
    property p_glob;
        glob_clr && (det == '0) |=> (alarm_r & RESMASK) == '0;
    endproperty
    a_glob: assert property (p_glob) else $error("reset left alarm"); // see RQ10
    property p_key;
        !glob_clr |=> $countones($past(alarm_r) & ~alarm_r) <= 1;
    endproperty
    a_key: assert property (p_key) else $error("keypad cleared several"); // see RQ12
    property p_ospd;
        spd_x10 > max_x11 |=> alarm_r[`SALR_AL_OSPD];
    endproperty
    a_ospd: assert property (p_ospd) else $error("overspeed missed"); // see RQ15
    property p_latch;
        !glob_clr && !key_req |=> (alarm_r & $past(alarm_r)) == $past(alarm_r);
    endproperty
    a_latch: assert property (p_latch) else $error("alarm dropped"); // see RQ16
    property p_post;
        $fell(any_r) |-> disp.item == $past(sel_r);
    endproperty
    a_post: assert property (p_post) else $error("post-clear item wrong"); // see RQ9
    c_alarm: cover property ($rose(any_r));
    c_hold: cover property (key_hold_req);
    c_seq: cover property (seq_req ##1 !any_r);
endmodule // salr_top

// ---- tb/salr_host_keypad.sv ----
module salr_host_keypad import salr_pkg::*; (
    input wire logic core_clk, // System clock
    output salr_pins_t pins // Power, host and keypad pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // All sources idle low at start
    initial pins = '0;
    // Apply or remove the power sources
    task automatic set_power(input logic ctrl, input logic main);
        @(posedge core_clk);
        pins.ctrl_pwr <= ctrl;
        pins.main_pwr <= main;
    endtask
    // Host clear pulse: on for a few cycles, then off
    task automatic pulse_clear();
        @(posedge core_clk);
        pins.fault_clr <= 1'b1;
        repeat (3) @(posedge core_clk);
        pins.fault_clr <= 1'b0;
    endtask
    // Hold up and down together for n cycles
    task automatic hold_keys(input int n);
        @(posedge core_clk);
        pins.key_up <= 1'b1;
        pins.key_down <= 1'b1;
        repeat (n) @(posedge core_clk);
        pins.key_up <= 1'b0;
        pins.key_down <= 1'b0;
    endtask
    // Output transistor trip level
    task automatic set_trip(input logic v);
        @(posedge core_clk);
        pins.oc_hw_trip <= v;
    endtask
endmodule // salr_host_keypad

// ---- tb/salr_top_bench.sv ----
module salr_top_bench;
    import salr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BLK = 8;
    localparam int HLD = 16;
    logic core_clk = 1'b0;
    logic reset_n = 1'b0;
    salr_pins_t pins;
    logic [28:0] alarm_det = '0;
    logic menu = 1'b0;
    logic [15:0] current_meas = '0;
    logic [15:0] speed_meas = '0;
    logic [7:0] awaddr = '0;
    logic [7:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    salr_disp_t disp;
    logic charge_led, run_permit, irq;
    int err_count = 0;
    int n_tests = 0;
    int cyc = 0;
    logic [31:0] rv;
    logic [1:0] rs;
    // Clock at 50 MHz
    always #10 core_clk = ~core_clk;
    salr_host_keypad salr_host_keypad_inst (.core_clk(core_clk), .pins(pins));
    salr_top #(.BLINK_CYC(BLK), .HOLD_CYC(HLD)) salr_top_inst (
        .core_clk(core_clk), .reset_n(reset_n), .pins(pins), .alarm_det(alarm_det),
        .keypad_test_menu_item(menu), .current_meas(current_meas), .speed_meas(speed_meas),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .disp(disp),
        .charge_led(charge_led), .run_permit(run_permit), .irq(irq));
    // Verdict and end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Hang guard
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            finish_test();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // Bus write; a ready seen mid-cycle completes its channel at the next rising edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_ok;
        logic w_ok;
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        while (!(aw_ok && w_ok))
        begin
            @(negedge core_clk);
            aw_ok = aw_ok || (awready === 1'b1);
            w_ok = w_ok || (wready === 1'b1);
            @(posedge core_clk);
            if (aw_ok)
                awvalid <= 1'b0;
            if (w_ok)
                wvalid <= 1'b0;
        end
        @(negedge core_clk);
        while (bvalid !== 1'b1)
        begin
            @(negedge core_clk);
        end
        rs = bresp;
        @(posedge core_clk);
        bready <= 1'b0;
    endtask
    // Bus read; response data taken while rvalid stands, before the accepting edge
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(negedge core_clk);
        while (arready !== 1'b1)
        begin
            @(negedge core_clk);
        end
        @(posedge core_clk);
        arvalid <= 1'b0;
        @(negedge core_clk);
        while (rvalid !== 1'b1)
        begin
            @(negedge core_clk);
        end
        rv = rdata;
        rs = rresp;
        @(posedge core_clk);
        rready <= 1'b0;
    endtask
    // One-cycle detector pulse
    task automatic pulse_det(input logic [28:0] m);
        @(posedge core_clk);
        alarm_det <= m;
        @(posedge core_clk);
        alarm_det <= '0;
    endtask
    task automatic t_power();
        salr_host_keypad_inst.set_power(1'b1, 1'b0);
        tick(4);
        check("lit", disp.lit, 1'b1);
        check("permit no main", run_permit, 1'b0);
        salr_host_keypad_inst.set_power(1'b1, 1'b1);
        tick(4);
        check("charge", charge_led, 1'b1);
        check("permit", run_permit, 1'b1);
        rd(8'h14);
        check("rated reset", rv, 32'h0000FFFF);
        rd(8'h18);
        check("maxspd reset", rv, 32'h0000FFFF);
        rd(8'h40);
        check("unmapped", rs, 2'b10);
        wr(8'h40, 32'h0);
        check("unmapped wr", rs, 2'b10);
        rd(8'h08);
        check("info", rv, 32'h00000700);
        $display("test power done");
    endtask
    task automatic t_latch();
        int k;
        wr(8'h10, 32'h3);
        pulse_det(29'h1 << 14);
        tick(2);
        check("code", disp.code, 5'h0F);
        check("shown", disp.show_alarm, 1'b1);
        check("permit alarm", run_permit, 1'b0);
        check("irq", irq, 1'b1);
        k = 0;
        while (disp.led_orange !== 1'b1 && k < 100)
        begin
            tick(1);
            k++;
        end
        k = 0;
        while (disp.led_orange === 1'b1 && k < 100)
        begin
            tick(1);
            k++;
        end
        check("blink", k, BLK);
        check("held", disp.code, 5'h0F);
        wr(8'h0C, 32'h1);
        tick(1);
        check("irq w1c", irq, 1'b0);
        wr(8'h00, 32'h51);
        tick(3);
        rd(8'h04);
        check("sw reset", rv, 32'h0);
        check("item", disp.item, 4'h5);
        check("show off", disp.show_alarm, 1'b0);
        rd(8'h0C);
        check("istat", rv, 32'h2);
        wr(8'h0C, 32'h3);
        $display("test latch done");
    endtask
    task automatic t_serious();
        pulse_det((29'h1 << 7) | (29'h1 << 14));
        tick(2);
        check("code serious", disp.code, 5'h08);
        salr_host_keypad_inst.pulse_clear();
        tick(8);
        rd(8'h04);
        check("pin reset", rv, 32'h80);
        @(posedge core_clk);
        menu <= 1'b1;
        @(posedge core_clk);
        menu <= 1'b0;
        salr_host_keypad_inst.hold_keys(HLD + 8);
        tick(4);
        rd(8'h04);
        check("serious stays", rv, 32'h80);
        @(posedge core_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        tick(4);
        rd(8'h04);
        check("power cycle", rv, 32'h0);
        check("lit again", disp.lit, 1'b1);
        $display("test serious done");
    endtask
    task automatic t_keypad();
        pulse_det((29'h1 << 3) | (29'h1 << 14));
        @(posedge core_clk);
        menu <= 1'b1;
        @(posedge core_clk);
        menu <= 1'b0;
        tick(2);
        rd(8'h04);
        check("menu one", rv, 32'h4000);
        check("next code", disp.code, 5'h0F);
        salr_host_keypad_inst.hold_keys(HLD - 1);
        tick(4);
        rd(8'h04);
        check("short hold", rv, 32'h4000);
        salr_host_keypad_inst.hold_keys(HLD + 8);
        tick(4);
        rd(8'h04);
        check("long hold", rv, 32'h0);
        $display("test keypad done");
    endtask
    task automatic t_detect();
        wr(8'h14, 32'h64);
        wr(8'h18, 32'h64);
        @(posedge core_clk);
        current_meas <= 16'h0064;
        speed_meas <= 16'h006E;
        tick(3);
        check("at limits", disp.code, 5'h00);
        @(posedge core_clk);
        current_meas <= 16'h0065;
        tick(2);
        check("fw oc", disp.code, 5'h02);
        @(posedge core_clk);
        current_meas <= 16'h0000;
        speed_meas <= 16'h006F;
        wr(8'h00, 32'h1);
        tick(3);
        check("overspeed", disp.code, 5'h03);
        @(posedge core_clk);
        speed_meas <= 16'h0000;
        wr(8'h00, 32'h1);
        salr_host_keypad_inst.set_trip(1'b1);
        tick(4);
        check("hw oc", disp.code, 5'h01);
        salr_host_keypad_inst.set_trip(1'b0);
        wr(8'h00, 32'h1);
        tick(3);
        check("all clear", disp.code, 5'h00);
        $display("test detect done");
    endtask
    // Main sequence
    initial
    begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'b1;
        t_power();
        t_latch();
        t_serious();
        t_keypad();
        t_detect();
        finish_test();
    end
endmodule // salr_top_bench
